// [pkg/trace_port_params.svh]
/*
 * Offsets, field positions, reset values and timing counts of the serial
 * trace byte port. Assumes inclusion by the design file.
 */
`ifndef TRACE_PORT_PARAMS_SVH
`define TRACE_PORT_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define TRC_DATA_OFS 8'h00
`define TRC_CTRL_OFS 8'h04

// ----------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------
`define TRC_EN_BIT 0
`define TRC_EDGE_BIT 1
`define TRC_DIV_LSB 2
`define TRC_DIV_MSB 3
`define TRC_GAP_LSB 4
`define TRC_GAP_MSB 6

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TRC_DATA_RST 8'h00
`define TRC_GAP_RST 3'h0
`define TRC_DIV_RST 2'h0
`define TRC_EDGE_RST 1'b0
`define TRC_EN_RST 1'b0

// ----------------------------------------------------------------------
// Timing and sizing
// ----------------------------------------------------------------------
`define TRC_BITS_PER_BYTE 8
`define TRC_HALVES_PER_BYTE 5'h10
`define TRC_FIFO_DEPTH 16

`endif

// [pkg/trace_port_pkg.sv]
/*
 * Types of the serial trace byte port.
 * Assumes the params header sits in the include path.
 */
package trace_port_pkg;

    // ------------------------------------------------------------------
    // Control register contents
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] packet_gap_count;
        logic [1:0] div_sel;
        logic edge_sel;
        logic clk_en;
    } trace_ctrl_s;

    // ------------------------------------------------------------------
    // Host request carrier
    // ------------------------------------------------------------------
    typedef struct packed {
        logic sel;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LEAD = 2'b01,
        ST_SHIFT = 2'b10,
        ST_GAP = 2'b11
    } shift_state_e;

endpackage : trace_port_pkg

// [rtl/serial_trace_port.sv]
/*
 * Serial trace byte port: register host port, byte FIFO and two-wire
 * clock/data serialiser. Assumes one clock core_clk and a host that keeps
 * its request steady while host_ready is low.
 */
`timescale 1ns/1ps
`include "trace_port_params.svh"

module trace_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign in_ready = (count_q != (AW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_ptr_q];

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_entry
        always_ff @(posedge core_clk or negedge arst_n)
        begin
            if (!arst_n)
                mem_q[i] <= '0;
            else if (push && (wr_ptr_q == AW'(i)))
                mem_q[i] <= in_data;
        end
    end

    // ------------------------------------------------------------------
    // Pointers and fill level
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= wr_ptr_q + AW'(1);
            if (pop)
                rd_ptr_q <= rd_ptr_q + AW'(1);
            if (push && !pop)
                count_q <= count_q + (AW+1)'(1);
            else if (pop && !push)
                count_q <= count_q - (AW+1)'(1);
        end
    end
endmodule : trace_byte_fifo

module serial_trace_port
    import trace_port_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Host register port
    input wire logic host_sel,
    input wire logic host_wr,
    input wire logic [7:0] host_addr,
    input wire logic [7:0] host_wdata,
    output logic host_ready,
    output logic [7:0] host_rdata,
    output logic host_rvalid,
    // Trace pins
    output logic trace_clock_out,
    output logic trace_serial_out,
    // Status
    output logic trace_busy
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    host_req_s req;
    trace_ctrl_s ctrl_q;
    shift_state_e state_q;
    logic [7:0] data_q, rdata_q, shreg_q, fifo_out_data;
    logic [4:0] half_q, gap_halves_q;
    logic [2:0] div_cnt_q;
    logic [1:0] div_lat_q;
    logic rvalid_q, edge_lat_q, clk_q, dat_q;
    logic data_hit, ctrl_hit, accept, tick;
    logic fifo_in_ready, fifo_out_valid, fifo_pop;

    // Half trace clock period in core clocks, minus one
    function automatic logic [2:0] half_len_m1(input logic [1:0] sel);
        if (sel == 2'h0)
            return 3'h0;
        else if (sel == 2'h1)
            return 3'h1;
        return 3'h3; // Reserved code runs as the slowest rate
    endfunction : half_len_m1

    // ------------------------------------------------------------------
    // Host decode
    // ------------------------------------------------------------------
    assign req = '{sel: host_sel, wr: host_wr, addr: host_addr, wdata: host_wdata};

    always_comb
    begin
        data_hit = 1'b0;
        ctrl_hit = 1'b0;
        if (req.addr == `TRC_DATA_OFS)
            data_hit = 1'b1;
        else if (req.addr == `TRC_CTRL_OFS)
            ctrl_hit = 1'b1;
    end

    // Data writes wait for the shifter to finish and for FIFO room
    assign host_ready = !(req.sel && req.wr && data_hit
                          && ((state_q != ST_IDLE) || !fifo_in_ready));
    assign accept = req.sel && host_ready;
    assign host_rdata = rdata_q;
    assign host_rvalid = rvalid_q;

    // ------------------------------------------------------------------
    // Data register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            data_q <= `TRC_DATA_RST;
        else if (accept && req.wr && data_hit)
            data_q <= req.wdata;
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_q.packet_gap_count <= `TRC_GAP_RST;
            ctrl_q.div_sel <= `TRC_DIV_RST;
            ctrl_q.edge_sel <= `TRC_EDGE_RST;
            ctrl_q.clk_en <= `TRC_EN_RST;
        end
        else if (accept && req.wr && ctrl_hit)
        begin
            ctrl_q.packet_gap_count <= req.wdata[`TRC_GAP_MSB:`TRC_GAP_LSB];
            ctrl_q.div_sel <= req.wdata[`TRC_DIV_MSB:`TRC_DIV_LSB];
            ctrl_q.edge_sel <= req.wdata[`TRC_EDGE_BIT];
            ctrl_q.clk_en <= req.wdata[`TRC_EN_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= accept && !req.wr;
            if (accept && !req.wr)
            begin
                if (data_hit)
                    rdata_q <= data_q;
                else if (ctrl_hit)
                    rdata_q <= {1'b0, ctrl_q}; // Bit 7 reads zero
                else
                    rdata_q <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------------
    // Byte buffer
    // ------------------------------------------------------------------
    // Writes made while clocking is off collect here until enabled
    trace_byte_fifo #(
        .WIDTH(8),
        .DEPTH(`TRC_FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .in_data(req.wdata),
        .in_valid(accept && req.wr && data_hit),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop)
    );

    // One byte leaves the buffer per transfer
    assign fifo_pop = (state_q == ST_IDLE) && ctrl_q.clk_en && fifo_out_valid;

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------
    // Everything below runs on core_clk; the trace clock is a divided level
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            div_cnt_q <= 3'h0;
        else if ((state_q == ST_IDLE) || tick || !ctrl_q.clk_en)
            div_cnt_q <= 3'h0;
        else
            div_cnt_q <= div_cnt_q + 3'h1;
    end

    assign tick = ctrl_q.clk_en && (state_q != ST_IDLE)
                  && (div_cnt_q == half_len_m1(div_lat_q));

    // ------------------------------------------------------------------
    // Shift sequencer
    // ------------------------------------------------------------------
    // Rate, edge and gap are latched per byte so a control write never tears a byte; clk_en acts at once and pauses it
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= ST_IDLE;
            shreg_q <= 8'h00;
            half_q <= 5'h00;
            gap_halves_q <= 5'h00;
            div_lat_q <= 2'h0;
            edge_lat_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    half_q <= 5'h00;
                    if (fifo_pop)
                    begin
                        shreg_q <= fifo_out_data;
                        div_lat_q <= ctrl_q.div_sel;
                        edge_lat_q <= ctrl_q.edge_sel;
                        gap_halves_q <= {1'b0, ctrl_q.packet_gap_count, 1'b1};
                        // Rising launch needs the clock brought low first
                        state_q <= ctrl_q.edge_sel ? ST_SHIFT : ST_LEAD;
                    end
                end
                ST_LEAD:
                    if (tick)
                        state_q <= ST_SHIFT;
                ST_SHIFT:
                begin
                    if (tick)
                    begin
                        if (half_q[0])
                            shreg_q <= {1'b0, shreg_q[7:1]};
                        if (half_q == `TRC_HALVES_PER_BYTE - 5'h01)
                        begin
                            half_q <= 5'h00;
                            state_q <= ST_GAP;
                        end
                        else
                            half_q <= half_q + 5'h01;
                    end
                end
                ST_GAP:
                begin
                    if (tick)
                    begin
                        if (half_q == gap_halves_q)
                        begin
                            half_q <= 5'h00;
                            state_q <= ST_IDLE;
                        end
                        else
                            half_q <= half_q + 5'h01;
                    end
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------
    // Registered so the pins never glitch on state decode
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            clk_q <= 1'b1;
            dat_q <= 1'b1;
        end
        else
        begin
            case (state_q)
                ST_LEAD:
                begin
                    clk_q <= 1'b0;
                    dat_q <= 1'b1;
                end
                ST_SHIFT:
                begin
                    // First half after the launch edge, second after sampling edge
                    if (!half_q[0])
                        clk_q <= !edge_lat_q;
                    else
                        clk_q <= edge_lat_q;
                    dat_q <= shreg_q[0];
                end
                default:
                begin
                    clk_q <= 1'b1;
                    dat_q <= 1'b1;
                end
            endcase
        end
    end

    assign trace_clock_out = clk_q;
    assign trace_serial_out = dat_q;
    assign trace_busy = (state_q != ST_IDLE);
    // No interrupt output exists on this block
endmodule : serial_trace_port

// [tb/serial_trace_port_asserts.sv]
/*
 * Assertions on the pins and host port of serial_trace_port.
 * Assumes a bind from the bench top file.
 */
`timescale 1ns/1ps
module serial_trace_port_chk (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Host port
    input wire logic host_sel,
    input wire logic host_wr,
    input wire logic [7:0] host_addr,
    input wire logic [7:0] host_wdata,
    input wire logic host_ready,
    input wire logic host_rvalid,
    // Trace pins and busy status
    input wire logic trace_clock_out,
    input wire logic trace_serial_out,
    input wire logic trace_busy
);
    // ----------
    // Assertions
    // ----------
    // Control shadow; valid as the bench only reconfigures while idle
    logic [7:0] ctrl_q;
    wire rd_ok = host_sel && !host_wr && host_ready;
    wire dwr = host_sel && host_wr && host_addr == 8'h00;
    wire clk_o = trace_clock_out;
    always_ff @(posedge core_clk or negedge arst_n)
        if (!arst_n)
            ctrl_q <= 8'h00;
        else if (host_sel && host_wr && host_ready && host_addr == 8'h04)
            ctrl_q <= host_wdata;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    chk_idle_pins_high: assert property (!trace_busy |-> clk_o && trace_serial_out)
        else $error("pin low while idle");
    chk_busy_wr_stall: assert property (trace_busy && dwr |-> !host_ready)
        else $error("data write taken while busy");
    chk_read_answer: assert property (rd_ok |=> host_rvalid)
        else $error("no read answer");
    chk_off_stays_idle: assert property (!ctrl_q[0] && !trace_busy |=> !trace_busy)
        else $error("transfer while disabled");
    chk_fast_half: assert property ($fell(clk_o) && ctrl_q[3:2] == 2'b00 |=> clk_o)
        else $error("fast half period wrong");
    chk_slow_half: assert property ($fell(clk_o) && ctrl_q[3:2] == 2'b10
        |-> (!clk_o) [*4] ##1 clk_o) else $error("slow half period wrong");
    chk_fall_launch: assert property (ctrl_q[1] && !clk_o && $changed(trace_serial_out)
        |-> $fell(clk_o)) else $error("data moved off falling edge");
    chk_sample_hold: assert property (!ctrl_q[1] && $fell(clk_o)
        |-> $stable(trace_serial_out)) else $error("data moved at sampling edge");
    cover property (dwr && trace_busy && !host_ready);
    cover property ($fell(clk_o) && ctrl_q[1]);
    cover property (host_rvalid);
endmodule : serial_trace_port_chk

// [tb/trace_receiver.sv]
/*
 * Trace receiver model: rebuilds bytes from the two trace pins.
 * Assumes edge_sel is set by the bench to match the control register.
 */
`timescale 1ns/1ps
module trace_receiver (
    // Clock for idle timing
    input wire logic core_clk,
    // Pins and setup
    input wire logic trace_clock_out,
    input wire logic trace_serial_out,
    input wire logic edge_sel,
    // Captured traffic
    output logic [7:0] rx_byte,
    output logic [7:0] rx_count,
    output logic [7:0] gap_run
);
    logic [7:0] sh;
    logic [7:0] hi = 8'h00;
    int nb = 0;
    logic in_frame = 1'b0;
    initial rx_count = 8'h00;
    task automatic take();
        sh = {trace_serial_out, sh[7:1]};
        if (++nb == 8)
        begin
            rx_byte = sh;
            rx_count++;
            nb = 0;
            in_frame = 1'b0;
        end
    endtask : take
    // First fall after idle opens a frame and carries no sample
    always @(negedge trace_clock_out)
        if (!in_frame)
        begin
            in_frame = 1'b1;
            gap_run = hi;
        end
        else if (!edge_sel)
            take();
    always @(posedge trace_clock_out)
        if (in_frame && edge_sel)
            take();
    always @(posedge core_clk)
        hi <= trace_clock_out ? hi + 8'h01 : 8'h00;
endmodule : trace_receiver

// [tb/serial_trace_byte_port_bench.sv]
/*
 * Self-checking bench of serial_trace_port with a trace receiver.
 * Assumes package, design, receiver and checker compiled first.
 */
`timescale 1ns/1ps
module serial_trace_byte_port_bench;
    // ----------
    // Wiring and shared tasks
    // ----------
    logic core_clk, arst_n, host_sel, host_wr, host_ready, host_rvalid;
    logic trace_clock_out, trace_serial_out, trace_busy, edge_cfg, rv_v;
    logic [7:0] host_addr, host_wdata, host_rdata, rx_byte, rx_count, gap_run, rd_v;
    int n_mismatch;
    int comparisons;
    int stall_v;
    serial_trace_port i_dut (
        .core_clk(core_clk), .arst_n(arst_n), .host_sel(host_sel), .host_wr(host_wr),
        .host_addr(host_addr), .host_wdata(host_wdata), .host_ready(host_ready),
        .host_rdata(host_rdata), .host_rvalid(host_rvalid), .trace_busy(trace_busy),
        .trace_clock_out(trace_clock_out), .trace_serial_out(trace_serial_out)
    );
    trace_receiver i_rx (
        .core_clk(core_clk), .trace_clock_out(trace_clock_out), .edge_sel(edge_cfg),
        .trace_serial_out(trace_serial_out), .rx_byte(rx_byte), .rx_count(rx_count),
        .gap_run(gap_run)
    );
    initial core_clk = 1'b0;
    always #50 core_clk = ~core_clk;
    task automatic summarize();
        $display("checks %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize
    task automatic fail();
        n_mismatch++;
        summarize();
    endtask : fail
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Request held until ready; the port has no abort
    task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
        @(negedge core_clk);
        host_sel = 1'b1;
        host_wr = wr;
        host_addr = addr;
        host_wdata = wd;
        stall_v = 0;
        #1;
        while (host_ready !== 1'b1)
        begin
            @(negedge core_clk);
            #1;
            if (++stall_v > 3000)
                fail();
        end
        @(negedge core_clk);
        rd_v = host_rdata;
        rv_v = host_rvalid;
        host_sel = 1'b0;
    endtask : bus
    task automatic rreg(input logic [7:0] a, input logic [7:0] exp, input string what);
        bus(1'b0, a, 8'h00);
        check(what, rd_v, exp);
        check({what, " valid"}, {7'h00, rv_v}, 8'h01);
    endtask : rreg
    task automatic wait_rx(input logic [7:0] n);
        for (int i = 0; rx_count !== n || trace_busy !== 1'b0; i++)
        begin
            @(negedge core_clk);
            if (i > 5000)
                fail();
        end
    endtask : wait_rx
    // ----------
    // Scenarios
    // ----------
    task automatic test_reset_regs();
        check("idle pins", {6'h00, trace_clock_out, trace_serial_out}, 8'h03);
        rreg(8'h00, 8'h00, "data reset");
        rreg(8'h04, 8'h00, "control reset");
        bus(1'b1, 8'h04, 8'hFE);
        rreg(8'h04, 8'h7E, "control fields");
        rreg(8'h08, 8'h00, "unmapped read");
        bus(1'b1, 8'h04, 8'h00);
    endtask : test_reset_regs
    task automatic test_fifo();
        for (int i = 0; i < 16; i++)
            bus(1'b1, 8'h00, 8'h40 + 8'(i));
        @(negedge core_clk);
        host_sel = 1'b1;
        host_wr = 1'b1;
        host_addr = 8'h00;
        #1;
        check("full refused", {7'h00, host_ready}, 8'h00);
        @(negedge core_clk);
        host_sel = 1'b0;
        check("no start", rx_count, 8'h00);
        rreg(8'h00, 8'h4F, "last write");
        bus(1'b1, 8'h04, 8'h01);
        wait_rx(8'd16);
        check("last byte", rx_byte, 8'h4F);
    endtask : test_fifo
    task automatic test_modes();
        logic [7:0] n;
        logic [7:0] b;
        for (int e = 0; e < 2; e++)
            for (int d = 0; d < 3; d++)
            begin
                edge_cfg = e[0];
                n = rx_count;
                b = 8'h1D + 8'(e * 64 + d * 5);
                bus(1'b1, 8'h04, {4'h0, d[1:0], e[0], 1'b1});
                bus(1'b1, 8'h00, b);
                wait_rx(n + 8'd1);
                check("mode byte", rx_byte, b);
                repeat (40) @(negedge core_clk);
                check("one byte", rx_count, n + 8'd1);
            end
    endtask : test_modes
    task automatic test_gap();
        logic [7:0] n;
        edge_cfg = 1'b0;
        for (int g = 0; g < 8; g += 7)
        begin
            n = rx_count;
            bus(1'b1, 8'h04, {1'b0, g[2:0], 4'h1});
            bus(1'b1, 8'h00, 8'hC3);
            bus(1'b1, 8'h00, 8'h3C);
            bus(1'b1, 8'h00, 8'h5A);
            check("stalled", {7'h00, stall_v > 0}, 8'h01);
            wait_rx(n + 8'd3);
            check("gap byte", rx_byte, 8'h5A);
            check("gap long", {7'h00, gap_run >= 8'(g * 2 + 1)}, 8'h01);
            check("gap short", {7'h00, gap_run <= 8'(g * 2 + 4)}, 8'h01);
        end
    endtask : test_gap
    initial
    begin
        n_mismatch = 0;
        comparisons = 0;
        arst_n = 1'b0;
        host_sel = 1'b0;
        host_wr = 1'b0;
        host_addr = 8'h00;
        host_wdata = 8'h00;
        edge_cfg = 1'b0;
        repeat (16) @(posedge core_clk);
        @(negedge core_clk);
        arst_n = 1'b1;
        test_reset_regs();
        test_fifo();
        test_modes();
        test_gap();
        summarize();
    end
endmodule : serial_trace_byte_port_bench
bind serial_trace_port serial_trace_port_chk i_chk (
    .core_clk(core_clk), .arst_n(arst_n), .host_sel(host_sel), .host_wr(host_wr),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_ready(host_ready),
    .host_rvalid(host_rvalid), .trace_busy(trace_busy),
    .trace_clock_out(trace_clock_out), .trace_serial_out(trace_serial_out)
);
